/* inc/tocmp_cfg.svh */
// Register offsets, field positions and reset values of the compare channel.
`ifndef TOCMP_CFG_SVH
`define TOCMP_CFG_SVH
`define TOCMP_OFS_CTRL 6'h00
`define TOCMP_OFS_POL 6'h01
`define TOCMP_OFS_LOCK 6'h02
`define TOCMP_OFS_CCR 6'h03
`define TOCMP_OFS_STAT 6'h04
`define TOCMP_CTRL_MODE_HI 14
`define TOCMP_CTRL_MODE_LO 12
`define TOCMP_CTRL_PE_BIT 11
`define TOCMP_CTRL_DIR_HI 9
`define TOCMP_CTRL_DIR_LO 8
`define TOCMP_POL_P_BIT 0
`define TOCMP_POL_N_BIT 1
`define TOCMP_LOCK_HI 1
`define TOCMP_LOCK_LO 0
`define TOCMP_LOCK_FULL 2'h3
`define TOCMP_DIR_OUTPUT 2'h0
`define TOCMP_RST_MODE 3'h0
`define TOCMP_RST_DIR 2'h0
`define TOCMP_RST_LOCK 2'h0
`define TOCMP_RST_CCR 16'h0000
`endif

/* inc/tocmp_pkg.sv */
// Types shared by the compare channel modules.
`default_nettype none
package tocmp_pkg;
    typedef enum logic [2:0] {
        OCM_FREEZE = 3'h0,
        OCM_SET = 3'h1,
        OCM_CLEAR = 3'h2,
        OCM_TOGGLE = 3'h3,
        OCM_FORCE_LOW = 3'h4,
        OCM_FORCE_HIGH = 3'h5,
        OCM_PWM_ONE = 3'h6,
        OCM_PWM_TWO = 3'h7
    } tocmp_mode_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } tocmp_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } tocmp_wb_rsp_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic down;
        logic update;
    } tocmp_tmr_t;
endpackage : tocmp_pkg
`default_nettype wire

/* rtl/tocmp_wb.sv */
// Classic Wishbone slave front end with a fixed one-cycle answer.
`timescale 1ns/10ps
`default_nettype none
module tocmp_wb (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // Bus side.
    input wire tocmp_pkg::tocmp_wb_req_t wb_req,
    output tocmp_pkg::tocmp_wb_rsp_t wb_rsp,
    // Register file side.
    input wire logic [31:0] rd_data,
    output logic wr_stb,
    output logic [5:0] reg_idx
);
    tocmp_pkg::tocmp_wb_rsp_t st_q;
    tocmp_pkg::tocmp_wb_rsp_t st_d;
    logic req;

    assign req = wb_req.cyc & wb_req.stb;
    // The write lands on the edge at which the master sees ack.
    assign wr_stb = req & wb_req.we & st_q.ack;
    assign reg_idx = wb_req.adr[7:2];
    assign wb_rsp = st_q;

    always_comb
    begin
        st_d = st_q;
        st_d.ack = req & ~st_q.ack;
        if (req & ~st_q.ack)
        begin
            st_d.dat = wb_req.we ? 32'h0000_0000 : rd_data;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end
endmodule : tocmp_wb
`default_nettype wire

/* rtl/tocmp_top.sv */
// Output-compare channel of a general-purpose timer with its register file.
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "tocmp_cfg.svh"
module tocmp_top (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // Register bus.
    input wire tocmp_pkg::tocmp_wb_req_t wb_req,
    output tocmp_pkg::tocmp_wb_rsp_t wb_rsp,
    // Timer core.
    input wire tocmp_pkg::tocmp_tmr_t tmr,
    // Channel outputs.
    output logic output_reference,
    output logic primary_channel_output,
    output logic complementary_channel_output
);
    typedef struct packed {
        tocmp_pkg::tocmp_mode_t mode;
        tocmp_pkg::tocmp_mode_t prev_mode;
        logic preload_en;
        logic [1:0] dir_sel;
        logic pol_p;
        logic pol_n;
        logic [1:0] lock;
        logic [15:0] ccr_pre;
        logic [15:0] ccr_act;
        logic ref_lvl;
        logic prev_lvl;
        logic out_p;
        logic out_n;
    } tocmp_st_t;

    tocmp_st_t st_q;
    tocmp_st_t st_d;
    logic wr_stb;
    logic [5:0] reg_idx;
    logic [31:0] rd_data;
    logic cmp_eq;
    logic cmp_gt;
    logic pwm_lvl;
    logic mode_locked;
    logic [31:0] wr_ctrl;
    logic [31:0] wr_pol;
    logic [31:0] wr_lock;
    logic [31:0] wr_ccr;

    // Byte lanes not selected keep their old contents.
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // Level that a pulse mode asks for from the comparison result.
    function automatic logic pulse_level(
        input tocmp_pkg::tocmp_mode_t mode,
        input logic down,
        input logic gt
    );
        logic lvl;
        lvl = down ? gt : ~gt;
        if (mode == tocmp_pkg::OCM_PWM_TWO)
        begin
            lvl = ~lvl;
        end
        return lvl;
    endfunction : pulse_level

    function automatic logic is_pulse(input tocmp_pkg::tocmp_mode_t mode);
        return (mode == tocmp_pkg::OCM_PWM_ONE) || (mode == tocmp_pkg::OCM_PWM_TWO);
    endfunction : is_pulse

    tocmp_wb u_wb (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .wb_req(wb_req),
        .wb_rsp(wb_rsp),
        .rd_data(rd_data),
        .wr_stb(wr_stb),
        .reg_idx(reg_idx)
    );

    assign cmp_eq = (tmr.cnt == st_q.ccr_act);
    assign cmp_gt = (tmr.cnt > st_q.ccr_act);
    assign pwm_lvl = pulse_level(st_q.mode, tmr.down, cmp_gt);
    assign mode_locked = (st_q.lock == `TOCMP_LOCK_FULL)
        && (st_q.dir_sel == `TOCMP_DIR_OUTPUT);

    always_comb
    begin
        rd_data = 32'h0000_0000;
        wr_ctrl = 32'h0000_0000;
        wr_ctrl[`TOCMP_CTRL_MODE_HI:`TOCMP_CTRL_MODE_LO] = st_q.mode;
        wr_ctrl[`TOCMP_CTRL_PE_BIT] = st_q.preload_en;
        wr_ctrl[`TOCMP_CTRL_DIR_HI:`TOCMP_CTRL_DIR_LO] = st_q.dir_sel;
        wr_pol = 32'h0000_0000;
        wr_pol[`TOCMP_POL_P_BIT] = st_q.pol_p;
        wr_pol[`TOCMP_POL_N_BIT] = st_q.pol_n;
        wr_lock = 32'h0000_0000;
        wr_lock[`TOCMP_LOCK_HI:`TOCMP_LOCK_LO] = st_q.lock;
        // Reads see the preload copy, as software wrote it.
        wr_ccr = {16'h0000, st_q.ccr_pre};
        unique case (reg_idx)
            `TOCMP_OFS_CTRL: rd_data = wr_ctrl;
            `TOCMP_OFS_POL: rd_data = wr_pol;
            `TOCMP_OFS_LOCK: rd_data = wr_lock;
            `TOCMP_OFS_CCR: rd_data = wr_ccr;
            `TOCMP_OFS_STAT: rd_data = {28'h0000000, cmp_gt, st_q.out_n,
                st_q.out_p, st_q.ref_lvl};
            default: rd_data = 32'h0000_0000;
        endcase
        wr_ctrl = merge_bytes(wr_ctrl, wb_req.dat, wb_req.sel);
        wr_pol = merge_bytes(wr_pol, wb_req.dat, wb_req.sel);
        wr_lock = merge_bytes(wr_lock, wb_req.dat, wb_req.sel);
        wr_ccr = merge_bytes(wr_ccr, wb_req.dat, wb_req.sel);
    end

    always_comb
    begin
        st_d = st_q;
        st_d.prev_mode = st_q.mode;
        st_d.prev_lvl = pwm_lvl;

        // Register writes.
        if (wr_stb)
        begin
            unique case (reg_idx)
                `TOCMP_OFS_CTRL:
                begin
                    if (!mode_locked)
                    begin
                        st_d.mode = tocmp_pkg::tocmp_mode_t'(
                            wr_ctrl[`TOCMP_CTRL_MODE_HI:`TOCMP_CTRL_MODE_LO]);
                    end
                    st_d.preload_en = wr_ctrl[`TOCMP_CTRL_PE_BIT];
                    st_d.dir_sel = wr_ctrl[`TOCMP_CTRL_DIR_HI:`TOCMP_CTRL_DIR_LO];
                end
                `TOCMP_OFS_POL:
                begin
                    st_d.pol_p = wr_pol[`TOCMP_POL_P_BIT];
                    st_d.pol_n = wr_pol[`TOCMP_POL_N_BIT];
                end
                `TOCMP_OFS_LOCK:
                begin
                    st_d.lock = wr_lock[`TOCMP_LOCK_HI:`TOCMP_LOCK_LO];
                end
                `TOCMP_OFS_CCR:
                begin
                    st_d.ccr_pre = wr_ccr[15:0];
                end
                default:
                begin
                    st_d.lock = st_q.lock;
                end
            endcase
        end

        // Shadow compare register.
        if (st_q.preload_en)
        begin
            if (tmr.update)
            begin
                st_d.ccr_act = st_q.ccr_pre;
            end
        end
        else if (wr_stb && (reg_idx == `TOCMP_OFS_CCR))
        begin
            st_d.ccr_act = wr_ccr[15:0];
        end

        // Reference level.
        unique case (st_q.mode)
            tocmp_pkg::OCM_FREEZE:
            begin
                st_d.ref_lvl = st_q.ref_lvl;
            end
            tocmp_pkg::OCM_SET:
            begin
                if (cmp_eq)
                begin
                    st_d.ref_lvl = 1'b1;
                end
            end
            tocmp_pkg::OCM_CLEAR:
            begin
                if (cmp_eq)
                begin
                    st_d.ref_lvl = 1'b0;
                end
            end
            tocmp_pkg::OCM_TOGGLE:
            begin
                if (cmp_eq)
                begin
                    st_d.ref_lvl = ~st_q.ref_lvl;
                end
            end
            tocmp_pkg::OCM_FORCE_LOW:
            begin
                st_d.ref_lvl = 1'b0;
            end
            tocmp_pkg::OCM_FORCE_HIGH:
            begin
                st_d.ref_lvl = 1'b1;
            end
            tocmp_pkg::OCM_PWM_ONE, tocmp_pkg::OCM_PWM_TWO:
            begin
                // A switch from a force mode into the first pulse mode keeps the old level until the
                // comparison moves; leaving freeze, a switch into the second pulse mode, or one from it into the first, reloads it.
                if ((pwm_lvl != st_q.prev_lvl)
                    || (st_q.prev_mode == tocmp_pkg::OCM_FREEZE))
                begin
                    st_d.ref_lvl = pwm_lvl;
                end
            end
        endcase

        // Pins follow the next reference so they line up with it.
        st_d.out_p = st_d.ref_lvl ^ st_d.pol_p;
        st_d.out_n = ~st_d.ref_lvl ^ st_d.pol_n;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= '{mode: tocmp_pkg::OCM_FREEZE, prev_mode: tocmp_pkg::OCM_FREEZE,
                preload_en: 1'b0, dir_sel: `TOCMP_RST_DIR, pol_p: 1'b0, pol_n: 1'b0,
                lock: `TOCMP_RST_LOCK, ccr_pre: `TOCMP_RST_CCR,
                ccr_act: `TOCMP_RST_CCR, ref_lvl: 1'b0, prev_lvl: 1'b0,
                out_p: 1'b0, out_n: 1'b1};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign output_reference = st_q.ref_lvl;
    assign primary_channel_output = st_q.out_p;
    assign complementary_channel_output = st_q.out_n;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    sequence s_ccr_write;
        wr_stb && (reg_idx == `TOCMP_OFS_CCR) && (wb_req.sel == 4'hF);
    endsequence

    sequence s_ctrl_write;
        wr_stb && (reg_idx == `TOCMP_OFS_CTRL);
    endsequence

    property p_freeze_hold;
        (st_q.mode == tocmp_pkg::OCM_FREEZE) |=> (st_q.ref_lvl == $past(st_q.ref_lvl));
    endproperty
    a_freeze_hold: assert property (p_freeze_hold)
        else $error("Reference moved in freeze mode.");

    property p_set_on_match;
        (st_q.mode == tocmp_pkg::OCM_SET) && cmp_eq |=> st_q.ref_lvl;
    endproperty
    a_set_on_match: assert property (p_set_on_match)
        else $error("Reference not set on match.");

    property p_clear_on_match;
        (st_q.mode == tocmp_pkg::OCM_CLEAR) && cmp_eq |=> !st_q.ref_lvl;
    endproperty
    a_clear_on_match: assert property (p_clear_on_match)
        else $error("Reference not cleared on match.");

    property p_toggle_on_match;
        (st_q.mode == tocmp_pkg::OCM_TOGGLE) && cmp_eq |=> $changed(st_q.ref_lvl);
    endproperty
    a_toggle_on_match: assert property (p_toggle_on_match)
        else $error("Reference did not toggle on match.");

    property p_force_low;
        (st_q.mode == tocmp_pkg::OCM_FORCE_LOW) [*2] |-> !st_q.ref_lvl;
    endproperty
    a_force_low: assert property (p_force_low)
        else $error("Reference not low in forced low mode.");

    property p_force_high;
        (st_q.mode == tocmp_pkg::OCM_FORCE_HIGH) [*2] |-> st_q.ref_lvl;
    endproperty
    a_force_high: assert property (p_force_high)
        else $error("Reference not high in forced high mode.");

    property p_pwm_one_up;
        (st_q.mode == tocmp_pkg::OCM_PWM_ONE) && !tmr.down && cmp_gt && st_q.prev_lvl
            |=> !st_q.ref_lvl;
    endproperty
    a_pwm_one_up: assert property (p_pwm_one_up)
        else $error("First pulse mode kept level above compare.");

    property p_pwm_two_down;
        (st_q.mode == tocmp_pkg::OCM_PWM_TWO) && tmr.down && cmp_gt && st_q.prev_lvl
            |=> !st_q.ref_lvl;
    endproperty
    a_pwm_two_down: assert property (p_pwm_two_down)
        else $error("Second pulse mode kept level above compare.");

    property p_mode_locked;
        s_ctrl_write and mode_locked |=> $stable(st_q.mode);
    endproperty
    a_mode_locked: assert property (p_mode_locked)
        else $error("Mode changed under full lock.");

    property p_pwm_steady;
        is_pulse(st_q.mode) && (pwm_lvl == st_q.prev_lvl)
            && (st_q.prev_mode != tocmp_pkg::OCM_FREEZE) |=> $stable(st_q.ref_lvl);
    endproperty
    a_pwm_steady: assert property (p_pwm_steady)
        else $error("Pulse mode moved without a result change.");

    property p_polarity;
        (primary_channel_output == (output_reference ^ st_q.pol_p))
            && (complementary_channel_output == (!output_reference ^ st_q.pol_n));
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("Channel outputs disagree with reference.");

    property p_preload_wait;
        st_q.preload_en && !tmr.update |=> $stable(st_q.ccr_act);
    endproperty
    a_preload_wait: assert property (p_preload_wait)
        else $error("Shadow compare changed without update.");

    property p_direct_write;
        s_ccr_write and !st_q.preload_en |=> (st_q.ccr_act == $past(wb_req.dat[15:0]));
    endproperty
    a_direct_write: assert property (p_direct_write)
        else $error("Direct compare write not applied.");
endmodule : tocmp_top
`default_nettype wire

/* dv/tocmp_pin_model.sv */
// Load model that watches the two channel pins from outside the block.
`timescale 1ns/10ps
`default_nettype none
module tocmp_pin_model (
    // Clock.
    input wire logic clk_sys,
    // Pins from the channel.
    input wire logic pin_p,
    input wire logic pin_n,
    // Levels seen by the load.
    output logic seen_p,
    output logic seen_n
);
    // The load samples the pins one edge late, as an external flop would.
    always_ff @(posedge clk_sys)
    begin
        seen_p <= pin_p;
        seen_n <= pin_n;
    end
endmodule : tocmp_pin_model
`default_nettype wire

/* dv/timer_channel_output_compare_tb.sv */
// Self-checking bench of the output-compare channel.
`timescale 1ns/10ps
`default_nettype none
module timer_channel_output_compare_tb;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    tocmp_pkg::tocmp_wb_req_t wb_req = '0;
    tocmp_pkg::tocmp_wb_rsp_t wb_rsp;
    tocmp_pkg::tocmp_tmr_t tmr = '0;
    logic oref, pout, nout, seen_p, seen_n;
    logic [31:0] exp_q[$];
    int num_errors = 0;
    int n_checks = 0;
    logic [15:0] v, w, ccr_a;
    logic [1:0] pol;
    logic pe = 1'b0;

    always #2.5 clk_sys = ~clk_sys;

    tocmp_top dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .tmr(tmr), .output_reference(oref), .primary_channel_output(pout),
        .complementary_channel_output(nout));
    tocmp_pin_model pin_u (.clk_sys(clk_sys), .pin_p(pout), .pin_n(nout), .seen_p(seen_p),
        .seen_n(seen_n));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_checks++;
        if (seen !== expv)
        begin
            num_errors++;
            $display("FAIL t=%0t got %h want %h", $time, seen, expv);
        end
    endtask : check

    // The master holds the whole request until it samples ack, then idles a cycle.
    // No cycle count is assumed; a slave that never answers is left to the watchdog.
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_req <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
        do
        begin
            @(posedge clk_sys);
        end
        while (wb_rsp.ack !== 1'b1);
        wb_req <= '0;
        @(posedge clk_sys);
    endtask : bus

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        bus(1'b1, adr, dat);
    endtask : wr

    task automatic rd(input logic [7:0] adr, input logic [31:0] expv);
        exp_q.push_back(expv);
        bus(1'b0, adr, 32'h0000_0000);
    endtask : rd

    function automatic logic [31:0] stat(input logic r);
        stat = {28'h0, tmr.cnt > ccr_a, ~r ^ pol[1], r ^ pol[0], r};
    endfunction : stat

    task automatic look(input logic r);
        rd(8'h10, stat(r));
        check({31'h0, seen_p}, {31'h0, r ^ pol[0]});
        check({31'h0, seen_n}, {31'h0, ~r ^ pol[1]});
        check({31'h0, oref}, {31'h0, r});
    endtask : look

    task automatic step(input logic [2:0] m, input logic [15:0] c, input logic dn, input logic r);
        tmr.cnt <= c;
        tmr.down <= dn;
        wr(8'h00, {17'h0, m, pe, 11'h0});
        @(posedge clk_sys);
        look(r);
    endtask : step

    // The counter sits on the compare value for exactly one cycle.
    task automatic pulse(input logic r);
        tmr.cnt <= ccr_a;
        @(posedge clk_sys);
        tmr.cnt <= ccr_a + 16'h0001;
        @(posedge clk_sys);
        @(posedge clk_sys);
        look(r);
    endtask : pulse

    // Read answers are compared in order of request as ack shows them.
    always @(posedge clk_sys)
        if (wb_rsp.ack === 1'b1 && wb_req.cyc === 1'b1 && wb_req.we === 1'b0)
            check(wb_rsp.dat, exp_q.pop_front());

    initial
    begin
        #(20000 * 5);
        num_errors++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(32'hDC142279));
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        check({29'h0, oref, pout, nout}, 32'h0000_0001);
        rd(8'h00, 32'h0000_0000);
        rd(8'h0C, 32'h0000_0000);
        $display("test reset done");
        v = 16'($urandom_range(60000, 100));
        pol = 2'($urandom_range(3, 0));
        ccr_a = v;
        wr(8'h04, {30'h0, pol});
        wr(8'h0C, {16'h0, v});
        rd(8'h0C, {16'h0, v});
        step(3'h5, v + 16'h0001, 1'b0, 1'b1);
        step(3'h4, v + 16'h0001, 1'b0, 1'b0);
        step(3'h1, v + 16'h0001, 1'b0, 1'b0);
        pulse(1'b1);
        step(3'h2, v + 16'h0001, 1'b0, 1'b1);
        pulse(1'b0);
        step(3'h3, v + 16'h0001, 1'b0, 1'b0);
        pulse(1'b1);
        pulse(1'b0);
        step(3'h5, v + 16'h0001, 1'b0, 1'b1);
        step(3'h0, v + 16'h0001, 1'b0, 1'b1);
        pulse(1'b1);
        $display("test match modes done");
        step(3'h6, v + 16'h0001, 1'b0, 1'b0);
        step(3'h6, v, 1'b0, 1'b1);
        step(3'h6, v + 16'h0001, 1'b0, 1'b0);
        step(3'h6, v + 16'h0001, 1'b1, 1'b1);
        step(3'h6, v, 1'b1, 1'b0);
        step(3'h0, v + 16'h0001, 1'b0, 1'b0);
        step(3'h7, v + 16'h0001, 1'b0, 1'b1);
        step(3'h7, v, 1'b0, 1'b0);
        step(3'h7, v + 16'h0001, 1'b1, 1'b0);
        step(3'h7, v, 1'b1, 1'b1);
        step(3'h7, v + 16'h0001, 1'b1, 1'b0);
        $display("test pulse modes done");
        pe = 1'b1;
        step(3'h4, v + 16'h0001, 1'b0, 1'b0);
        w = v + 16'h01F4;
        wr(8'h0C, {16'h0, w});
        rd(8'h0C, {16'h0, w});
        look(1'b0);
        tmr.update <= 1'b1;
        @(posedge clk_sys);
        tmr.update <= 1'b0;
        ccr_a = w;
        @(posedge clk_sys);
        look(1'b0);
        $display("test preload done");
        wr(8'h08, 32'h0000_0003);
        rd(8'h08, 32'h0000_0003);
        wr(8'h00, {17'h0, 3'h5, 1'b0, 11'h0});
        rd(8'h00, {17'h0, 3'h4, 1'b0, 11'h0});
        $display("test lock done");
        wr(8'h20, $urandom());
        rd(8'h20, 32'h0000_0000);
        $display("test unmapped done");
        report_and_stop();
    end
endmodule : timer_channel_output_compare_tb
`default_nettype wire
